// *** bench/clock_select_checker_sva.sv ***
// Port checker for the base clock selector
`timescale 1ns/10ps

module clock_select_checker (
  input wire        clk,
  input wire        rst_n,
  input wire        system_osc_enable,
  input wire        base_clock_out,
  input wire        base_source_vco,
  input wire        switch_busy,
  input wire        osc_enable,
  input wire        pll_enable,
  input wire        feedback_tick,
  input wire [11:0] feedback_divisor,
  input wire [10:0] vco_center_mult,
  input wire [27:0] vco_center_hz
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Two busy cycles in a row, and a held system enable
  sequence s_busy_two;
    switch_busy ##1 switch_busy;
  endsequence
  sequence s_osc_held;
    system_osc_enable [*4];
  endsequence

  property p_divisor_nonzero;
    feedback_divisor != 12'h000;
  endproperty
  a_divisor_nonzero: assert property (p_divisor_nonzero)
    else $error("feedback divisor reads zero");
  property p_freeze;
    s_busy_two |-> $stable(base_clock_out);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("base clock moved during a switch");
  // Source flips only as the switch completes
  property p_source_swap;
    $changed(base_source_vco) |-> $fell(switch_busy);
  endproperty
  a_source_swap: assert property (p_source_swap)
    else $error("source changed outside switch end");
  property p_switch_bound;
    $rose(switch_busy) |-> ##[1:700] !switch_busy;
  endproperty
  a_switch_bound: assert property (p_switch_bound)
    else $error("switch did not complete");
  // Sampled sources are at most a sixth of clk, so toggles are spaced
  property p_half_rate;
    $changed(base_clock_out) |=> $stable(base_clock_out) [*2];
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("base clock toggled too fast");
  property p_zero_range;
    pll_enable |-> vco_center_mult != 11'h000;
  endproperty
  a_zero_range: assert property (p_zero_range)
    else $error("pll enabled with zero linear multiplier");
  property p_center;
    $stable(vco_center_mult) [*2] |-> vco_center_hz == vco_center_mult * 28'd71400;
  endproperty
  a_center: assert property (p_center)
    else $error("center frequency mismatch");
  property p_osc_follow;
    s_osc_held |-> osc_enable;
  endproperty
  a_osc_follow: assert property (p_osc_follow)
    else $error("oscillator enable does not follow system");
  property p_tick_enabled;
    feedback_tick |-> pll_enable || $past(pll_enable);
  endproperty
  a_tick_enabled: assert property (p_tick_enabled)
    else $error("feedback tick with pll disabled");
endmodule

bind pll_base_clock_select clock_select_checker i_chk (
  .clk(clk), .rst_n(rst_n), .system_osc_enable(system_osc_enable),
  .base_clock_out(base_clock_out), .base_source_vco(base_source_vco),
  .switch_busy(switch_busy), .osc_enable(osc_enable), .pll_enable(pll_enable),
  .feedback_tick(feedback_tick), .feedback_divisor(feedback_divisor),
  .vco_center_mult(vco_center_mult), .vco_center_hz(vco_center_hz)
);

// *** bench/system_side_model.sv ***
// Model of the system side: oscillator enable and base clock edge count
`timescale 1ns/10ps

module system_side_model (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        stop_req,
  input  wire        base_clock_out,
  output reg         system_osc_enable,
  output reg  [15:0] base_rises
);
  reg last_base;

  // Stop mode drops the enable; counting edges lets the bench judge the rate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_osc_enable <= 1'b1;
      last_base         <= 1'b0;
      base_rises        <= 16'h0000;
    end else begin
      system_osc_enable <= !stop_req;
      last_base         <= base_clock_out;
      if (base_clock_out && !last_base)
        base_rises <= base_rises + 16'h0001;
    end
  end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the base clock selector
`timescale 1ns/10ps
`include "pll_clock_consts.vh"
`define CHK(got, exp) check_val((got), (exp))

module testbench;
  reg         clk, rst_n, wr_en, rd_en, crystal_clock, vco_clock, stop_req;
  reg  [7:0]  addr, wr_data;
  reg  [15:0] rises0;
  wire [7:0]  rd_data;
  wire        system_osc_enable, base_clock_out, base_source_vco, switch_busy;
  wire        osc_enable, pll_enable, feedback_tick;
  wire [11:0] feedback_divisor;
  wire [1:0]  vco_power_range;
  wire [10:0] vco_center_mult;
  wire [27:0] vco_center_hz;
  wire [15:0] base_rises;
  integer     err_count, n_tests;

  pll_base_clock_select i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .system_osc_enable(system_osc_enable),
    .base_clock_out(base_clock_out), .base_source_vco(base_source_vco),
    .switch_busy(switch_busy), .osc_enable(osc_enable), .pll_enable(pll_enable),
    .feedback_tick(feedback_tick), .feedback_divisor(feedback_divisor),
    .vco_power_range(vco_power_range), .vco_center_mult(vco_center_mult),
    .vco_center_hz(vco_center_hz));
  system_side_model i_sys (.clk(clk), .rst_n(rst_n), .stop_req(stop_req),
    .base_clock_out(base_clock_out), .system_osc_enable(system_osc_enable),
    .base_rises(base_rises));

  // Sources sit 1 ns off the clk grid; each stands still while its enable is low
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #1;
    forever #20 crystal_clock = osc_enable ? ~crystal_clock : 1'b0;
  end
  initial begin
    #1;
    forever #12 vco_clock = pll_enable ? ~vco_clock : 1'b0;
  end

  task check_val(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Bus tasks start and end just after a rising edge; a gap cycle avoids double drives
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    begin
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      `CHK(rd_data, exp);
      @(posedge clk);
    end
  endtask
  task wait_busy(input logic lvl);
    integer i;
    begin
      i = 0;
      #1;
      while (switch_busy !== lvl && i < 1000) begin
        @(posedge clk);
        #1;
        i = i + 1;
      end
      if (i == 1000) begin
        err_count = err_count + 1;
        summarize;
      end
      @(posedge clk);
    end
  endtask
  // Feedback ticks over 240 cycles; a small N keeps the window short
  task tick_rate(input integer lo, input integer hi);
    integer t;
    begin
      t = 0;
      repeat (240) begin
        @(posedge clk);
        #1;
        if (feedback_tick === 1'b1)
          t = t + 1;
      end
      `CHK((t >= lo) && (t <= hi), 1'b1);
      @(posedge clk);
    end
  endtask
  // Base clock rises over 800 ns must be half the source rises
  task rate(input logic [15:0] lo, input logic [15:0] hi);
    begin
      rises0 = base_rises;
      repeat (200) @(posedge clk);
      `CHK((base_rises - rises0 >= lo) && (base_rises - rises0 <= hi), 1'b1);
    end
  endtask

  initial begin
    rst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00; wr_data = 8'h00;
    crystal_clock = 1'b0; vco_clock = 1'b0; stop_req = 1'b0;
    err_count = 0; n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`CTRL_ADDR, 8'h20);
    rd(`MULT_HIGH_ADDR, 8'h00);
    rd(`MULT_LOW_ADDR, 8'h40);
    rd(`RANGE_ADDR, 8'h40);
    rd(`CONFIG_TWO_ADDR, 8'h00);
    rd(8'h37, 8'h00);
    wr(`MULT_LOW_ADDR, 8'h05);
    wr(`CTRL_ADDR, 8'h22);
    rd(`MULT_LOW_ADDR, 8'h40);
    rd(`CTRL_ADDR, 8'h20);
    wr(`CTRL_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h10);
    rd(`CTRL_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h30);
    rd(`CTRL_ADDR, 8'h20);
    wr(`CTRL_ADDR, 8'h00);
    // Program N = 0, E = 1, L = 0x45 with the PLL off
    wr(`MULT_LOW_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h01);
    wr(`RANGE_ADDR, 8'h45);
    rd(`RANGE_ADDR, 8'h45);
    rd(`CTRL_ADDR, 8'h01);
    `CHK(feedback_divisor, 32'h001);
    `CHK(vco_power_range, 32'h1);
    `CHK(vco_center_mult, 32'h08a);
    `CHK(vco_center_hz, 32'h08a * 32'd71400);
    wr(`MULT_HIGH_ADDR, 8'h01);
    wr(`MULT_LOW_ADDR, 8'h05);
    rd(`MULT_HIGH_ADDR, 8'h01);
    `CHK(feedback_divisor, 32'h105);
    // Power on, then select the VCO in a second write
    wr(`CTRL_ADDR, 8'h21);
    rate(16'd9, 16'd11);
    wr(`CTRL_ADDR, 8'h31);
    wait_busy(1'b1);
    wait_busy(1'b0);
    `CHK(base_source_vco, 1'b1);
    rd(`STATUS_ADDR, 8'h05);
    rate(16'd15, 16'd18);
    wr(`CTRL_ADDR, 8'h11);
    rd(`CTRL_ADDR, 8'h31);
    wr(`CTRL_ADDR, 8'h21);
    wait_busy(1'b1);
    wait_busy(1'b0);
    `CHK(base_source_vco, 1'b0);
    // A zero linear multiplier keeps the crystal in charge
    wr(`CTRL_ADDR, 8'h01);
    wr(`RANGE_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h21);
    wr(`CTRL_ADDR, 8'h31);
    rd(`CTRL_ADDR, 8'h21);
    `CHK(pll_enable, 1'b0);
    // N = 2 with the loop running: one tick per two VCO rises, about 20 in the window
    wr(`CTRL_ADDR, 8'h01);
    wr(`MULT_HIGH_ADDR, 8'h00);
    wr(`MULT_LOW_ADDR, 8'h02);
    wr(`RANGE_ADDR, 8'h45);
    wr(`CTRL_ADDR, 8'h21);
    `CHK(feedback_divisor, 32'h002);
    tick_rate(18, 21);
    // Stop mode with and without the keep bit
    stop_req <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(osc_enable, 1'b0);
    wr(`CONFIG_TWO_ADDR, 8'h01);
    repeat (4) @(posedge clk);
    `CHK(osc_enable, 1'b1);
    rd(`CONFIG_TWO_ADDR, 8'h01);
    stop_req <= 1'b0;
    @(posedge clk);
    summarize;
  end
endmodule

// *** verilog/clock_edge_sync.v ***
// Two-flop synchroniser for a sampled clock pin with rising edge detection
`timescale 1ns/10ps

module clock_edge_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire async_in,
  output wire level,
  output wire rise
);

  reg meta;
  reg stable;
  reg last;

  // First stage feeds only the second; edge logic looks at later stages
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else begin
      meta   <= async_in;
      stable <= meta;
      last   <= stable;
    end
  end

  assign level = stable;
  assign rise  = stable & ~last;

endmodule

// *** verilog/pll_base_clock_select.v ***
// Base clock selector with PLL programming registers and interlocks
//
// Function
// - Zero feedback multiplier behaves as one
// - Zero linear multiplier disables PLL, forces crystal
// - Switch waits three crystal and three VCO edges
// - Base clock held static during a switch
// - Selected source divided by two
// - Select bit chooses crystal or VCO source
// - Select one means VCO, zero means crystal
// - Select cannot be set while PLL off
// - PLL power bit stays on while VCO selected; stop without keep bit still drops pll_enable
// - Power and select never change together
// - Exponent held binary in control register
// - Feedback multiplier split over high, low
// - Linear multiplier held in range register
// - Feedback divider locks VCO to N times reference
// - Center frequency is L times 2^E times step
// - Programming registers read-only while PLL on
// - System enable drives oscillator and PLL
// - Keep bit holds oscillator on in stop
// - Keep bit clear: oscillator follows system enable
`timescale 1ns/10ps
`include "pll_clock_consts.vh"

module pll_base_clock_select (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  addr,
  input  wire [7:0]  wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [7:0]  rd_data,
  input  wire        crystal_clock,
  input  wire        vco_clock,
  input  wire        system_osc_enable,
  output reg         base_clock_out,
  output reg         base_source_vco,
  output reg         switch_busy,
  output reg         osc_enable,
  output reg         pll_enable,
  output wire        feedback_tick,
  output wire [11:0] feedback_divisor,
  output reg  [1:0]  vco_power_range,
  output reg  [10:0] vco_center_mult,
  output reg  [27:0] vco_center_hz
);

  // Transition controller states
  localparam ST_RUN   = 2'd0;
  localparam ST_DRAIN = 2'd1;
  localparam ST_ARM   = 2'd2;

  // Software state
  reg        pll_power_on_bit;
  reg        base_clock_select_bit;
  reg [1:0]  vco_power_range_field;
  reg [3:0]  multiplier_select_high;
  reg [7:0]  multiplier_select_low;
  reg [7:0]  vco_range_select;
  reg        stop_mode_osc_keep;

  // Transition controller state
  reg [1:0]  state;
  reg [1:0]  edge_count;
  reg [7:0]  idle_timer;
  reg        target_sel;

  // System enable crosses in from another module's clocking
  reg        osc_en_meta;
  reg        osc_en_sync;

  // Returns one when an 8-bit field is not zero
  function nonzero8;
    input [7:0] value;
    begin
      nonzero8 = |value;
    end
  endfunction

  // Wait count for one side of the switch
  function [1:0] wait_edges;
    input vco_side;
    begin
      wait_edges = vco_side ? `VCO_WAIT_EDGES : `XTAL_WAIT_EDGES;
    end
  endfunction

  wire xtal_level;
  wire xtal_rise;
  wire vco_level;
  wire vco_rise;

  // Each source is synchronised on its own path
  clock_edge_sync xtal_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (crystal_clock),
    .level    (xtal_level),
    .rise     (xtal_rise)
  );

  clock_edge_sync vco_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (vco_clock),
    .level    (vco_level),
    .rise     (vco_rise)
  );

  // Feedback divider uses the full split multiplier
  vco_feedback_divider feedback_div (
    .clk           (clk),
    .rst_n         (rst_n),
    .enable        (pll_enable),
    .vco_rise      (vco_rise),
    .multiplier    ({multiplier_select_high, multiplier_select_low}),
    .feedback_tick (feedback_tick),
    .divisor       (feedback_divisor)
  );

  // Write decode
  wire wr_ctrl  = wr_en && (addr == `CTRL_ADDR);
  wire wr_high  = wr_en && (addr == `MULT_HIGH_ADDR);
  wire wr_low   = wr_en && (addr == `MULT_LOW_ADDR);
  wire wr_range = wr_en && (addr == `RANGE_ADDR);
  wire wr_cfg   = wr_en && (addr == `CONFIG_TWO_ADDR);
  wire range_ok = nonzero8(vco_range_select);

  reg next_pll_on;
  reg next_bcs;

  // Interlocks judged against the values before this write
  always @* begin
    next_pll_on = pll_power_on_bit;
    next_bcs    = base_clock_select_bit & range_ok;
    if (wr_ctrl) begin
      // Clearing power is refused while the VCO is selected
      next_pll_on = wr_data[`PLL_POWER_ON_BIT_BIT] | base_clock_select_bit;
      // Setting select needs power already on and staying on; a select that
      // is already set survives a refused power-off in the same write
      next_bcs    = wr_data[`BCS_BIT] & range_ok
                    & (base_clock_select_bit
                       | (pll_power_on_bit & wr_data[`PLL_POWER_ON_BIT_BIT]));
    end
  end

  // Register storage; programming fields lock while the PLL power bit is set
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_power_on_bit      <= `PLL_POWER_ON_BIT_RESET;
      base_clock_select_bit <= `BCS_RESET;
      vco_power_range_field <= `VPR_RESET;
      multiplier_select_high <= `MULT_HIGH_RESET;
      multiplier_select_low <= `MULT_LOW_RESET;
      vco_range_select      <= `RANGE_RESET;
      stop_mode_osc_keep    <= `OSC_KEEP_RESET;
    end else begin
      pll_power_on_bit      <= next_pll_on;
      base_clock_select_bit <= next_bcs;
      if (wr_ctrl && !pll_power_on_bit) begin
        vco_power_range_field <= wr_data[`VPR_HI:`VPR_LO];
      end
      if (wr_high && !pll_power_on_bit) begin
        multiplier_select_high <= wr_data[3:0];
      end
      if (wr_low && !pll_power_on_bit) begin
        multiplier_select_low <= wr_data;
      end
      if (wr_range && !pll_power_on_bit) begin
        vco_range_select <= wr_data;
      end
      if (wr_cfg) begin
        stop_mode_osc_keep <= wr_data[`OSC_KEEP_BIT];
      end
    end
  end

  // Read data lands in the cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `CTRL_ADDR: begin
          rd_data <= {2'b00, pll_power_on_bit, base_clock_select_bit,
                      2'b00, vco_power_range_field};
        end
        `MULT_HIGH_ADDR:  rd_data <= {4'h0, multiplier_select_high};
        `MULT_LOW_ADDR:   rd_data <= multiplier_select_low;
        `RANGE_ADDR:      rd_data <= vco_range_select;
        `CONFIG_TWO_ADDR: rd_data <= {7'h00, stop_mode_osc_keep};
        `STATUS_ADDR: begin
          rd_data <= {5'h00, pll_enable, switch_busy, base_source_vco};
        end
        default:          rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // Oscillator and PLL enables; stop mode shows as the system enable falling
  wire next_osc_en = osc_en_sync | stop_mode_osc_keep;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_meta <= 1'b0;
      osc_en_sync <= 1'b0;
      osc_enable  <= 1'b0;
      pll_enable  <= 1'b0;
    end else begin
      osc_en_meta <= system_osc_enable;
      osc_en_sync <= osc_en_meta;
      osc_enable  <= next_osc_en;
      // A zero linear multiplier keeps the loop off even when powered
      pll_enable  <= pll_power_on_bit & range_ok & next_osc_en;
    end
  end

  // Center frequency multiplier and its value in Hz
  wire [10:0] next_center = {3'b000, vco_range_select} << vco_power_range_field;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_power_range <= 2'h0;
      vco_center_mult <= 11'h000;
      vco_center_hz   <= 28'h0000000;
    end else begin
      vco_power_range <= vco_power_range_field;
      vco_center_mult <= next_center;
      vco_center_hz   <= {17'h00000, next_center} * `F_NOM_HZ;
    end
  end

  // Old source is the one in use, new is the requested one
  wire old_rise = base_source_vco ? vco_rise  : xtal_rise;
  wire old_low  = base_source_vco ? ~vco_level : ~xtal_level;
  wire new_rise = target_sel ? vco_rise  : xtal_rise;
  wire new_low  = target_sel ? ~vco_level : ~xtal_level;
  // Sampling at clk limits sources to well under half the clk rate
  wire act_rise = base_source_vco ? vco_rise : xtal_rise;

  // Transition controller: drain old source, arm new, then hand over
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ST_RUN;
      edge_count      <= 2'd0;
      idle_timer      <= 8'h00;
      target_sel      <= 1'b0;
      base_source_vco <= 1'b0;
      switch_busy     <= 1'b0;
      base_clock_out  <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (act_rise) begin
            base_clock_out <= ~base_clock_out;
          end
          if (base_clock_select_bit != base_source_vco) begin
            target_sel  <= base_clock_select_bit;
            state       <= ST_DRAIN;
            edge_count  <= 2'd0;
            idle_timer  <= 8'h00;
            switch_busy <= 1'b1;
          end
        end
        ST_DRAIN: begin
          // A stopped old source must not hang the switch
          if (old_rise) begin
            idle_timer <= 8'h00;
          end else if (idle_timer != `DRAIN_TIMEOUT) begin
            idle_timer <= idle_timer + 8'h01;
          end
          if (old_rise && edge_count != wait_edges(base_source_vco)) begin
            edge_count <= edge_count + 2'd1;
          end
          if ((edge_count == wait_edges(base_source_vco) && old_low)
              || idle_timer == `DRAIN_TIMEOUT) begin
            state      <= ST_ARM;
            edge_count <= 2'd0;
          end
        end
        ST_ARM: begin
          if (new_rise && edge_count != wait_edges(target_sel)) begin
            edge_count <= edge_count + 2'd1;
          end
          // New source joins only in its low phase, so no runt pulse
          if (edge_count == wait_edges(target_sel) && new_low) begin
            base_source_vco <= target_sel;
            state           <= ST_RUN;
            switch_busy     <= 1'b0;
          end
        end
        default: begin
          state       <= ST_RUN;
          switch_busy <= 1'b0;
        end
      endcase
      // Output keeps its level outside ST_RUN, giving no edges at all
    end
  end

endmodule

// *** verilog/pll_clock_consts.vh ***
// Register offsets, field positions, reset values and counts for the base clock selector
`ifndef PLL_CLOCK_CONSTS_VH
`define PLL_CLOCK_CONSTS_VH

// Register offsets on the 8-bit register port
`define CTRL_ADDR        8'h36
`define MULT_HIGH_ADDR   8'h38
`define MULT_LOW_ADDR    8'h39
`define RANGE_ADDR       8'h3a
`define CONFIG_TWO_ADDR  8'h3c
`define STATUS_ADDR      8'h3d

// Control register fields
`define PLL_POWER_ON_BIT_BIT        5
`define BCS_BIT          4
`define VPR_HI           1
`define VPR_LO           0

// Configuration and status fields
`define OSC_KEEP_BIT     0
`define STAT_ACTIVE_BIT  0
`define STAT_BUSY_BIT    1
`define STAT_PLLEN_BIT   2

// Reset values
`define PLL_POWER_ON_BIT_RESET      1'b1
`define BCS_RESET        1'b0
`define VPR_RESET        2'h0
`define MULT_HIGH_RESET  4'h0
`define MULT_LOW_RESET   8'h40
`define RANGE_RESET      8'h40
`define OSC_KEEP_RESET   1'b0

// Transition controller: source edges to wait on each side
`define XTAL_WAIT_EDGES  2'd3
`define VCO_WAIT_EDGES   2'd3
// Clock cycles without an old-source edge before it is taken as stopped
`define DRAIN_TIMEOUT    8'hff

// Nominal VCO center step in Hz
`define F_NOM_HZ         28'd71400

`endif

// *** verilog/vco_feedback_divider.v ***
// Modulo divider of the VCO clock by the feedback multiplier
`timescale 1ns/10ps

module vco_feedback_divider (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        enable,
  input  wire        vco_rise,
  input  wire [11:0] multiplier,
  output reg         feedback_tick,
  output reg  [11:0] divisor
);

  reg [11:0] count;
  reg [11:0] divisor_next_calc;

  // A zero multiplier divides exactly as one would
  always @* begin
    divisor_next_calc = (multiplier == 12'h000) ? 12'h001 : multiplier;
  end

  // One tick per divisor VCO edges; counter parks while the loop is off
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count         <= 12'h000;
      feedback_tick <= 1'b0;
      divisor       <= 12'h001;
    end else begin
      divisor       <= divisor_next_calc;
      feedback_tick <= 1'b0;
      if (!enable) begin
        count <= 12'h000;
      end else if (vco_rise) begin
        if (count + 12'h001 >= divisor_next_calc) begin
          count         <= 12'h000;
          feedback_tick <= 1'b1;
        end else begin
          count <= count + 12'h001;
        end
      end
    end
  end

endmodule
